// ==== rtl/sacp_pkg.sv ====
// constants and types of the sar converter serial conversion port
package sacp_pkg;
   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int CFG_BITS = 14;
   localparam logic [13:0] CFG_RESET = 14'h0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [1:0] VALID_CONV_COUNT = 2'h2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 25000000;
   localparam int CONV_TIME_NS = 2200;
   localparam int CONV_CYCLES =
      (CONV_TIME_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {
      SACP_IDLE,
      SACP_CONV,
      SACP_DONE
   } sacp_state_t;
endpackage : sacp_pkg

// ==== rtl/sacp_xfer_if.sv ====
// interface carrying frames between the link shifter and the core
`timescale 1ns/10ps
interface sacp_xfer_if;
   logic [15:0] tx_word;
   logic [13:0] cfg_word;
   logic frame_tgl;
   modport core (output tx_word, input cfg_word, input frame_tgl);
   modport link (input tx_word, output cfg_word, output frame_tgl);
endinterface : sacp_xfer_if

// ==== rtl/sacp_link.sv ====
// serial shifter running on the host's serial clock
`timescale 1ns/10ps
module sacp_link (
   input wire logic sclk_i,
   input wire logic resetn_i,
   input wire logic trig_i,
   input wire logic sdi_i,
   output logic sdo_o,
   sacp_xfer_if.link xf
);
   logic [4:0] cnt_reg;
   logic [13:0] shin_reg;
   logic [15:0] shout_reg;
   logic ld_reg;
   logic tgl_reg;
   logic frame_clr_n;
   // the link clock idles between frames, so no clock edge can clear the
   // frame logic; a high trigger holds it clear instead
   assign frame_clr_n = resetn_i & ~trig_i;
   // ----------------------------------------------------------------
   // bit counter on rising clock while trigger low
   // ----------------------------------------------------------------
   always_ff @(posedge sclk_i or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         cnt_reg <= 5'h00;
      end else if (cnt_reg != 5'h1F) begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end
   // captured word outlives the frame: the core fetches it only after
   // the toggle has crossed, which may be after the trigger rises
   always_ff @(posedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shin_reg <= 14'h0000;
         tgl_reg <= 1'b0;
      end else if (!trig_i && cnt_reg < 5'(sacp_pkg::CFG_BITS)) begin
         shin_reg <= {shin_reg[12:0], sdi_i};
         if (cnt_reg == 5'(sacp_pkg::CFG_BITS - 1)) begin
            tgl_reg <= ~tgl_reg; // word complete, tell core
         end
      end
   end
   assign xf.cfg_word = shin_reg;
   assign xf.frame_tgl = tgl_reg;
   // ----------------------------------------------------------------
   // launch on falling clock, msb first
   // ----------------------------------------------------------------
   // the first falling edge of a frame loads bits 14..0 of the result
   always_ff @(negedge sclk_i or negedge frame_clr_n) begin
      if (!frame_clr_n) begin
         shout_reg <= 16'h0000;
         ld_reg <= 1'b0;
      end else if (!ld_reg) begin
         shout_reg <= {xf.tx_word[14:0], 1'b0};
         ld_reg <= 1'b1;
      end else begin
         shout_reg <= {shout_reg[14:0], 1'b0};
      end
   end
   // first bit shows straight from the result word before any clock
   assign sdo_o = ld_reg ? shout_reg[15] : xf.tx_word[15];
endmodule : sacp_link

// ==== rtl/sacp_port.sv ====
// top of the sar converter serial conversion port
`timescale 1ns/10ps
module sacp_port #(
   parameter int CONV_CYCLES = sacp_pkg::CONV_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic sclk_i,
   input wire logic conversion_trigger_i,
   input wire logic sdi_i,
   input wire logic [15:0] sample_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic busy_o,
   output logic result_valid_o,
   output logic [13:0] cfg_o
);
   sacp_xfer_if xf ();
   sacp_pkg::sacp_state_t state_reg;
   logic [2:0] trig_sync_reg;
   logic [2:0] tgl_sync_reg;
   logic [sacp_pkg::CNT_W-1:0] conv_cnt_reg;
   logic [15:0] result_reg;
   logic [13:0] cfg_reg;
   logic [13:0] pend_cfg_reg;
   logic pend_reg;
   logic [1:0] settle_reg;
   logic sdo_link;
   logic trig_rise;
   logic frame_done;
   logic conv_start;
   localparam int CNT_W = sacp_pkg::CNT_W;
   // ----------------------------------------------------------------
   // link side shifter
   // ----------------------------------------------------------------
   sacp_link u_link (
      .sclk_i(sclk_i),
      .resetn_i(resetn_i),
      .trig_i(conversion_trigger_i),
      .sdi_i(sdi_i),
      .sdo_o(sdo_link),
      .xf(xf)
   );
   // result changes only at end of conversion; link reads it at frame start
   assign xf.tx_word = result_reg;
   // ----------------------------------------------------------------
   // synchronisers for trigger level and frame toggle
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trig_sync_reg <= 3'h0;
         tgl_sync_reg <= 3'h0;
      end else if (clk_en_i) begin
         trig_sync_reg <= {trig_sync_reg[1:0], conversion_trigger_i};
         tgl_sync_reg <= {tgl_sync_reg[1:0], xf.frame_tgl};
      end
   end
   assign trig_rise = trig_sync_reg[1] & ~trig_sync_reg[2];
   assign frame_done = tgl_sync_reg[1] ^ tgl_sync_reg[2];
   // only a rise seen while idle starts a conversion; the re-rise of the
   // during-conversion mode must not apply a pending configuration
   assign conv_start = trig_rise && state_reg == sacp_pkg::SACP_IDLE;
   // ----------------------------------------------------------------
   // conversion sequencer on the internal clock
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= sacp_pkg::SACP_IDLE;
         conv_cnt_reg <= '0;
         busy_o <= 1'b0;
      end else if (clk_en_i) begin
         case (state_reg)
            sacp_pkg::SACP_IDLE: begin
               if (trig_rise) begin
                  state_reg <= sacp_pkg::SACP_CONV;
                  conv_cnt_reg <= '0;
                  busy_o <= 1'b0;
               end
            end
            sacp_pkg::SACP_CONV: begin
               if (conv_cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
                  state_reg <= sacp_pkg::SACP_DONE;
                  // only the level at end of conversion counts; the
                  // during-conversion mode pulses the trigger low earlier
                  if (!trig_sync_reg[2]) begin
                     busy_o <= 1'b1;
                  end
               end else begin
                  conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
               end
            end
            sacp_pkg::SACP_DONE: begin
               state_reg <= sacp_pkg::SACP_IDLE;
            end
            default: begin
               state_reg <= sacp_pkg::SACP_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // result latch at end of conversion
   // ----------------------------------------------------------------
   // updated only at end of conversion; a frame in during-conversion
   // mode still reads the previous result
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_reg <= sacp_pkg::RESULT_RESET;
      end else if (clk_en_i && state_reg == sacp_pkg::SACP_DONE) begin
         result_reg <= sample_i;
      end
   end
   // ----------------------------------------------------------------
   // configuration: captured word applies at the next conversion
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_cfg_reg <= sacp_pkg::CFG_RESET;
         pend_reg <= 1'b0;
         cfg_reg <= sacp_pkg::CFG_RESET;
      end else if (clk_en_i) begin
         if (frame_done) begin
            pend_cfg_reg <= xf.cfg_word;
         end
         // a new frame wins over the clear from a starting conversion
         if (frame_done) begin
            pend_reg <= 1'b1;
         end else if (conv_start) begin
            pend_reg <= 1'b0;
         end
         if (conv_start && pend_reg) begin
            cfg_reg <= pend_cfg_reg;
         end
      end
   end
   assign cfg_o = cfg_reg;
   // ----------------------------------------------------------------
   // validity: two conversions after any change and after power-up
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         settle_reg <= 2'h0;
         result_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         if (conv_start && pend_reg && pend_cfg_reg != cfg_reg) begin
            settle_reg <= 2'h0;
            result_valid_o <= 1'b0;
         end else if (state_reg == sacp_pkg::SACP_DONE &&
                      settle_reg != sacp_pkg::VALID_CONV_COUNT) begin
            settle_reg <= settle_reg + 2'h1;
            result_valid_o <= (settle_reg + 2'h1 ==
               sacp_pkg::VALID_CONV_COUNT);
         end
      end
   end
   // ----------------------------------------------------------------
   // data out pin: released while trigger high
   // ----------------------------------------------------------------
   // pin follows the link clock domain directly; registering on the
   // system clock would add latency the host cannot tolerate
   assign sdo_o = sdo_link;
   assign sdo_oe_o = ~conversion_trigger_i;
endmodule : sacp_port

// ==== tb/sacp_port_checker.sv ====
// concurrent checks on the conversion port top
`timescale 1ns/10ps
module sacp_port_checker #(
   parameter int CONV_CYCLES = sacp_pkg::CONV_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic conversion_trigger_i,
   input wire logic sdo_oe_o,
   input wire logic busy_o,
   input wire logic result_valid_o,
   input wire logic [13:0] cfg_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   logic trig_q;
   logic [1:0] rise_cnt;
   logic [13:0] cfg_q;
   // trigger rises since the active config last moved; saturates
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trig_q <= 1'b0;
         cfg_q <= 14'h0000;
         rise_cnt <= 2'h0;
      end else begin
         trig_q <= conversion_trigger_i;
         cfg_q <= cfg_o;
         if (cfg_q != cfg_o) begin
            rise_cnt <= 2'h0;
         end else if (conversion_trigger_i && !trig_q &&
                      rise_cnt != 2'h3) begin
            rise_cnt <= rise_cnt + 2'h1;
         end
      end
   end
   property p_oe_lo; !conversion_trigger_i |-> sdo_oe_o; endproperty
   a_oe_lo: assert property (p_oe_lo) else $error("oe low");
   property p_oe_hi; conversion_trigger_i |-> !sdo_oe_o; endproperty
   a_oe_hi: assert property (p_oe_hi) else $error("oe high");
   property p_cfg_rise; !$stable(cfg_o) |-> conversion_trigger_i; endproperty
   a_cfg_rise: assert property (p_cfg_rise) else $error("cfg move");
   property p_frz; !clk_en_i |=> $stable(cfg_o) && $stable(result_valid_o);
   endproperty
   a_frz: assert property (p_frz) else $error("not frozen");
   property p_vdrop; !$stable(cfg_o) |=> !result_valid_o; endproperty
   a_vdrop: assert property (p_vdrop) else $error("valid kept");
   property p_vcnt; $rose(result_valid_o) |-> rise_cnt != 2'h0; endproperty
   a_vcnt: assert property (p_vcnt) else $error("valid early");
   property p_vkeep;
      result_valid_o && $stable(cfg_o) |=> result_valid_o || !$stable(cfg_o);
   endproperty
   a_vkeep: assert property (p_vkeep) else $error("valid lost");
   property p_busy; $rose(busy_o) |-> !conversion_trigger_i; endproperty
   a_busy: assert property (p_busy) else $error("busy cause");
endmodule : sacp_port_checker
bind sacp_port sacp_port_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
   .conversion_trigger_i(conversion_trigger_i), .sdo_oe_o(sdo_oe_o),
   .busy_o(busy_o), .result_valid_o(result_valid_o), .cfg_o(cfg_o));

// ==== tb/sacp_host_model.sv ====
// host serial master: trigger, link clock and config data
`timescale 1ns/10ps
module sacp_host_model (
   input wire logic sys_clk_i,
   input wire logic sdo_i,
   output logic sclk_o,
   output logic trig_o,
   output logic sdi_o
);
   initial begin
      sclk_o = 1'b0;
      trig_o = 1'b0;
      sdi_o = 1'b1;
   end
   // sixteen link clocks of 15 ns, msb first; link clock idles low
   task automatic shift16(input logic [15:0] tx, output logic [15:0] rx);
      #20;
      for (int i = 15; i >= 0; i--) begin
         sdi_o = tx[i];
         #7.5 sclk_o = 1'b1;
         rx[i] = sdo_i;
         #7.5 sclk_o = 1'b0;
      end
      sdi_o = ~sdi_o; // line inverted after the frame: no stale value
   endtask : shift16
   // one conversion then one 16-bit frame after it
   task automatic frame(input logic [15:0] tx, input int hold,
                        output logic [15:0] rx);
      @(negedge sys_clk_i);
      trig_o = 1'b1;
      repeat (hold) @(negedge sys_clk_i);
      trig_o = 1'b0;
      shift16(tx, rx);
   endtask : frame
   // fast host: frame inside the conversion, trigger back high at once
   // and the interface kept quiet until past the end of conversion
   task automatic frame_dc(input logic [15:0] tx, input int pre,
                           input int hold, output logic [15:0] rx);
      @(negedge sys_clk_i);
      trig_o = 1'b1;
      repeat (pre) @(negedge sys_clk_i);
      trig_o = 1'b0;
      shift16(tx, rx);
      trig_o = 1'b1;
      repeat (hold) @(negedge sys_clk_i);
      trig_o = 1'b0;
   endtask : frame_dc
endmodule : sacp_host_model

// ==== tb/testbench.sv ====
// self-checking bench for the conversion port
`timescale 1ns/10ps
module testbench;
   logic sys_clk_i, resetn_i, clk_en_i, sclk, trig, sdi, sdo, oe, busy, vld;
   logic [15:0] sample_i, rx;
   logic [13:0] cfg;
   int fail_count, n_compared;
   localparam int HOLD = sacp_pkg::CONV_CYCLES + 10;
   localparam logic [13:0] CA = 14'h2A5C;
   localparam logic [13:0] CB = 14'h1B7D;
   sacp_port u_sacp_port (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .clk_en_i(clk_en_i), .sclk_i(sclk), .conversion_trigger_i(trig),
      .sdi_i(sdi), .sample_i(sample_i), .sdo_o(sdo), .sdo_oe_o(oe),
      .busy_o(busy), .result_valid_o(vld), .cfg_o(cfg));
   sacp_host_model u_sacp_host_model (.sys_clk_i(sys_clk_i), .sdo_i(sdo),
      .sclk_o(sclk), .trig_o(trig), .sdi_o(sdi));
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic complete_run;
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   // result read in a frame is the conversion that just ended
   task automatic run(input logic [15:0] tx, input logic [15:0] smp);
      @(negedge sys_clk_i);
      sample_i = smp;
      u_sacp_host_model.frame(tx, HOLD, rx);
      chk(rx, smp);
   endtask : run
   // left-aligned word with junk tail, written twice before trusting
   task automatic t_setup;
      run({CA, 2'b11}, 16'hA5C3);
      run({CA, 2'b11}, 16'h5A3C);
      chk({2'h0, cfg}, {2'h0, CA});
      chk({15'h0, vld}, 16'h0000);
      run({CA, 2'b11}, 16'hF00F);
      chk({15'h0, vld}, 16'h0001);
      chk({15'h0, busy}, 16'h0000);
   endtask : t_setup
   // transfer during conversion reads the result before it
   task automatic t_during;
      @(negedge sys_clk_i);
      sample_i = 16'h3CC3;
      u_sacp_host_model.frame_dc({CA, 2'b11}, 8, HOLD, rx);
      chk(rx, 16'hF00F);
      sample_i = 16'hC33C;
      u_sacp_host_model.frame_dc({CA, 2'b11}, 8, HOLD, rx);
      chk(rx, 16'h3CC3);
      chk({15'h0, busy}, 16'h0000);
      chk({15'h0, vld}, 16'h0001);
      chk({2'h0, cfg}, {2'h0, CA});
   endtask : t_during
   // unshifted word: two zeros then upper twelve bits land
   task automatic t_right;
      run({2'b00, CB}, 16'h8001);
      run({2'b00, CB}, 16'h7FFE);
      chk({2'h0, cfg}, {4'h0, CB[13:2]});
      chk({15'h0, vld}, 16'h0000);
   endtask : t_right
   // trigger dropped long before the conversion ends
   task automatic t_busy;
      u_sacp_host_model.frame({2'b00, CB}, 10, rx);
      // busy is judged at end of conversion, well after the frame
      repeat (HOLD) @(negedge sys_clk_i);
      chk({15'h0, busy}, 16'h0001);
   endtask : t_busy
   initial begin
      fail_count = 0;
      n_compared = 0;
      resetn_i = 1'b0;
      clk_en_i = 1'b0;
      sample_i = 16'h0000;
      repeat (12) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      clk_en_i = 1'b1;
      t_setup();
      t_during();
      t_right();
      t_busy();
      complete_run();
   end
   // hang guard
   initial begin
      #100us;
      fail_count++;
      complete_run();
   end
endmodule : testbench
